//--- hw/swcsr_pkg.sv
/*
 swcsr_pkg: offsets, reset values, field positions, window map and
 state encodings of the switch station-address and direct-write block.
 assumes: a 12-bit byte address space seen from the AXI4-Lite slave.
*/
package swcsr_pkg;

  // ==========================================================
  // address map
  localparam int unsigned ADDR_W           = 12;
  localparam logic [11:0] OFF_CMD_STATUS   = 12'h1E0; // command status
  localparam logic [11:0] OFF_STATION_HIGH = 12'h1F0; // station addr high
  localparam logic [11:0] OFF_STATION_LOW  = 12'h1F4; // station addr low
  localparam logic [11:0] WIN_BASE         = 12'h200; // first window word
  localparam logic [11:0] WIN_LAST         = 12'h2DC; // last window word

  // ==========================================================
  // reset values and field positions
  localparam logic [15:0] RST_STATION_HIGH = 16'hFFFF;
  localparam logic [31:0] RST_STATION_LOW  = 32'hFF0F8000;
  localparam logic [31:0] RST_WIN_DATA     = 32'h00000000;
  localparam logic [3:0]  FAB_BE_ALL       = 4'hF;
  localparam int unsigned ST_BUSY_BIT      = 31; // status: busy
  localparam int unsigned ST_RNW_BIT       = 30; // status: read flag
  localparam int unsigned ST_BE_LSB        = 16; // status: enables
  localparam int unsigned HIGH_W           = 16; // used bits of high

  // ==========================================================
  // axi responses
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // ==========================================================
  // window word index to fabric register number
  localparam int unsigned WIN_ENTRIES = 56;
  localparam logic [15:0] WIN_MAP [WIN_ENTRIES] = '{
    16'h0001, 16'h0004,
    16'h0401, 16'h0440, 16'h0441, 16'h0480,
    16'h0801, 16'h0840, 16'h0841, 16'h0880,
    16'h0C01, 16'h0C40, 16'h0C41, 16'h0C80,
    16'h1800, 16'h1801, 16'h1802, 16'h1809, 16'h180B, 16'h180C,
    16'h1811, 16'h1812, 16'h1840, 16'h1841, 16'h1842, 16'h1843,
    16'h1845, 16'h1846, 16'h1847, 16'h1848, 16'h1849, 16'h184A,
    16'h184B, 16'h184D, 16'h1855, 16'h1856, 16'h1857, 16'h1880,
    16'h1C00, 16'h1C01, 16'h1C02, 16'h1C03, 16'h1C04, 16'h1C09,
    16'h1C0A, 16'h1C0C, 16'h1C0D, 16'h1C0E, 16'h1C0F, 16'h1C10,
    16'h1C11, 16'h1C12, 16'h1C13, 16'h1C14, 16'h1C15, 16'h1C20
  };

  // ==========================================================
  // fabric command engine states
  typedef enum logic [1:0] {
    FAB_IDLE = 2'b01,
    FAB_BUSY = 2'b10
  } swcsr_fab_state_e;

endpackage

//--- hw/swcsr_map_if.sv
/*
 swcsr_map_if: window index in, fabric register number out.
 assumes: one requester and one lookup table, same clock domain.
*/
`timescale 1ns/1ps
interface swcsr_map_if;
  logic [5:0]  idx; // window word index
  logic [15:0] num; // mapped fabric register number
  logic        hit; // index lies in the map
  modport req (output idx, input num, input hit);
  modport lut (input idx, output num, output hit);
endinterface

//--- hw/swcsr_win_map.sv
/*
 swcsr_win_map: combinational lookup of the direct-write window map.
 assumes: index counts words from the window base upward.
*/
`timescale 1ns/1ps
module swcsr_win_map
  import swcsr_pkg::*;
(
  swcsr_map_if.lut m
);

  // ==========================================================
  // lookup; only listed fabric registers are reachable
  always_comb begin
    if (m.idx < 6'(WIN_ENTRIES)) begin
      m.num = WIN_MAP[m.idx]; // see [R12] see [R13] see [R14] see [R15]
      m.hit = 1'b1;
    end else begin
      m.num = 16'h0000;
      m.hit = 1'b0;
    end
  end

endmodule

//--- hw/swcsr_top.sv
/*
 swcsr_top: AXI4-Lite register front end holding the switch station
 address and turning writes into a direct window into fabric commands.
 assumes: fabric pulses fab_done once per command; loader strobes its
 six bytes at power-on and pulses ldr_done when initialisation ends.
*/
// Behaviour
// [R1] high register: bits 15:0, upper bits zero
// [R2] low register: full 32 bits, read write
// [R3] both registers form pause frame address
// [R4] loader bytes 05h,06h fill high register
// [R5] loader bytes 01h..04h fill low register
// [R6] preload once, if programmed; host copies too
// [R7] after init host writes are kept
// [R8] window write: number, enables, write, busy
// [R9] busy clears when fabric write finishes
// [R10] window word carries data for fabric
// [R11] host never reads fabric through window
// [R12] reset and irq mask at 200h, 204h
// [R13] port registers map from 208h to 234h
// [R14] switch engine registers 238h to 294h
// [R15] buffer manager registers 298h to 2DCh
// [R16] byte enables gate the four data bytes; code always sends FAB_BE_ALL and ignores the write strobes
// [R17] host waits for idle before next command
`timescale 1ns/1ps
module swcsr_top
  import swcsr_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi write address
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic [2:0]        awprot,
  // axi write data
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  // axi write response
  output logic                   bvalid,
  input  wire logic              bready,
  output logic [1:0]             bresp,
  // axi read address
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic [2:0]        arprot,
  // axi read data
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  // eeprom loader
  input  wire logic              ldr_valid,
  input  wire logic              ldr_programmed,
  input  wire logic [47:0]       ldr_bytes,
  input  wire logic              ldr_done,
  // station address copies
  output logic [47:0]            station_addr,
  output logic [15:0]            host_station_addr_high,
  output logic [31:0]            host_station_addr_low,
  // fabric command side
  output logic                   fab_req,
  output logic [15:0]            fab_reg_number,
  output logic [3:0]             fab_byte_enables,
  output logic                   fab_read_not_write,
  output logic [31:0]            fab_wdata,
  input  wire logic              fab_done,
  output logic                   fabric_op_busy
);

  // ==========================================================
  // state
  logic [ADDR_W-1:0] aw_addr_q;   // held write address
  logic              aw_held_q;   // write address taken
  logic [31:0]       w_data_q;    // held write data
  logic [3:0]        w_strb_q;    // held write strobes
  logic              w_held_q;    // write data taken
  logic              bvalid_q;    // write response pending
  logic [1:0]        bresp_q;     // write response code
  logic              rvalid_q;    // read data pending
  logic [31:0]       rdata_q;     // read data
  logic [1:0]        rresp_q;     // read response code
  logic              init_done_q; // initialisation finished
  logic [15:0]       high_q;      // station address 47:32
  logic [31:0]       low_q;       // station address 31:0
  logic [15:0]       host_high_q; // host copy, high
  logic [31:0]       host_low_q;  // host copy, low
  swcsr_fab_state_e  fab_q;       // command engine state
  logic [15:0]       fab_num_q;   // command register number
  logic [3:0]        fab_be_q;    // command byte enables
  logic              fab_rnw_q;   // command read flag
  logic [31:0]       fab_data_q;  // command data

  // ==========================================================
  // decode of the held write
  logic              win_hit;  // write falls in window
  logic              wr_go;    // write performed this cycle
  logic              ldr_take; // loader preload accepted
  logic [ADDR_W-1:0] win_off;  // offset inside window
  logic [31:0]       low_mrg;  // low merged with strobes
  logic [31:0]       high_mrg; // high merged with strobes
  logic [31:0]       high_ext; // high register zero extended
  logic              rd_take;  // read address accepted
  swcsr_map_if       map ();   // window map lookup

  // window offset in bytes, word index from bits 7:2
  assign win_off = aw_addr_q - WIN_BASE;
  assign map.idx = win_off[7:2];

  // window range check, map must also hit
  assign win_hit = (aw_addr_q >= WIN_BASE) && (aw_addr_q <= WIN_LAST)
                   && map.hit;

  // write goes when both halves held, response free, fabric ready if window hit
  assign wr_go = aw_held_q && w_held_q && !bvalid_q
                 && !(win_hit && fab_q == FAB_BUSY); // see [R17]

  // loader only before initialisation ends
  assign ldr_take = ldr_valid && ldr_programmed && !init_done_q; // see [R6]

  // window map lookup table
  swcsr_win_map u_map (
    .m (map)
  );

  // ==========================================================
  // byte lane merge of host writes
  assign high_ext = {16'h0000, high_q};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign low_mrg[g*8+:8]  = w_strb_q[g] ? w_data_q[g*8+:8] : low_q[g*8+:8];
      assign high_mrg[g*8+:8] = w_strb_q[g] ? w_data_q[g*8+:8] : high_ext[g*8+:8];
    end
  endgenerate

  // ==========================================================
  // axi write channels: take address and data in either order
  assign awready = !aw_held_q;
  assign wready  = !w_held_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  // address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  // data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      // unmapped addresses answer slave error
      if (win_hit || aw_addr_q == OFF_STATION_HIGH
          || aw_addr_q == OFF_STATION_LOW || aw_addr_q == OFF_CMD_STATUS) begin
        bresp_q <= AXI_OKAY;
      end else begin
        bresp_q <= AXI_SLVERR;
      end
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // initialisation flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_done_q <= 1'b0;
    end else if (ldr_done) begin
      init_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // station address registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_q <= RST_STATION_HIGH; // see [R1]
      low_q  <= RST_STATION_LOW;  // see [R2]
    end else if (ldr_take) begin
      high_q <= ldr_bytes[47:32]; // see [R4]
      low_q  <= ldr_bytes[31:0];  // see [R5]
    end else if (wr_go && init_done_q) begin
      // host writes only after initialisation
      if (aw_addr_q == OFF_STATION_HIGH) begin
        high_q <= high_mrg[HIGH_W-1:0]; // see [R7] see [R1]
      end
      if (aw_addr_q == OFF_STATION_LOW) begin
        low_q <= low_mrg; // see [R7] see [R2]
      end
    end
  end

  // host copies follow the loader only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_high_q <= RST_STATION_HIGH;
      host_low_q  <= RST_STATION_LOW;
    end else if (ldr_take) begin
      host_high_q <= ldr_bytes[47:32]; // see [R6]
      host_low_q  <= ldr_bytes[31:0];  // see [R6]
    end
  end

  // pause frame source address
  assign station_addr           = {high_q, low_q}; // see [R3]
  assign host_station_addr_high = host_high_q;
  assign host_station_addr_low  = host_low_q;

  // ==========================================================
  // fabric command engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fab_q      <= FAB_IDLE;
      fab_num_q  <= '0;
      fab_be_q   <= '0;
      fab_rnw_q  <= 1'b0;
      fab_data_q <= RST_WIN_DATA; // see [R10]
    end else begin
      case (fab_q)
        FAB_IDLE: begin
          if (wr_go && win_hit) begin
            fab_q      <= FAB_BUSY;   // see [R8]
            fab_num_q  <= map.num;    // see [R8]
            fab_be_q   <= FAB_BE_ALL; // see [R8] see [R16]
            fab_rnw_q  <= 1'b0;       // see [R8]
            fab_data_q <= w_data_q;   // see [R10]
          end
        end
        FAB_BUSY: begin
          // fabric finished the write
          if (fab_done) begin
            fab_q <= FAB_IDLE; // see [R9]
          end
        end
        default: begin
          fab_q <= FAB_IDLE;
        end
      endcase
    end
  end

  // command outputs
  assign fab_req            = (fab_q == FAB_BUSY);
  assign fabric_op_busy     = (fab_q == FAB_BUSY);
  assign fab_reg_number     = fab_num_q;
  assign fab_byte_enables   = fab_be_q;
  assign fab_read_not_write = fab_rnw_q;
  assign fab_wdata          = fab_data_q;

  // ==========================================================
  // axi read channel
  assign arready = !rvalid_q;
  assign rd_take = arvalid && !rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

  // read data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= AXI_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q  <= AXI_OKAY;
      rdata_q  <= '0;
      if (araddr == OFF_STATION_HIGH) begin
        rdata_q <= {16'h0000, high_q}; // see [R1]
      end else if (araddr == OFF_STATION_LOW) begin
        rdata_q <= low_q; // see [R2]
      end else if (araddr == OFF_CMD_STATUS) begin
        rdata_q[ST_BUSY_BIT]         <= fab_q == FAB_BUSY;
        rdata_q[ST_RNW_BIT]          <= fab_rnw_q;
        rdata_q[ST_BE_LSB+:4]        <= fab_be_q;
        rdata_q[15:0]                <= fab_num_q;
      end else if (araddr >= WIN_BASE && araddr <= WIN_LAST) begin
        rdata_q <= '0; // write only window reads zero, see [R11]
      end else begin
        rresp_q <= AXI_SLVERR;
      end
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_win_cmd_load: assert property ( // see [R8]
    wr_go && win_hit && fab_q == FAB_IDLE |=> fabric_op_busy
      && fab_byte_enables == 4'hF && !fab_read_not_write
      && fab_wdata == $past(w_data_q))
    else $error("window write did not start a fabric write");

  a_busy_clear: assert property ( // see [R9]
    fabric_op_busy && fab_done |=> !fabric_op_busy)
    else $error("busy did not clear on completion");

  a_busy_hold: assert property ( // see [R9]
    fabric_op_busy && !fab_done |=> fabric_op_busy
      && $stable(fab_reg_number))
    else $error("busy dropped without completion");

  a_map_general: assert property ( // see [R12]
    wr_go && win_hit && aw_addr_q == 12'h204 |=> fab_reg_number == 16'h0004)
    else $error("irq mask window word mapped wrongly");

  a_map_port: assert property ( // see [R13]
    wr_go && win_hit && aw_addr_q == 12'h234 |=> fab_reg_number == 16'h0C80)
    else $error("port window word mapped wrongly");

  a_map_engine: assert property ( // see [R14]
    wr_go && win_hit && aw_addr_q == 12'h284 |=> fab_reg_number == 16'h184D)
    else $error("engine window word mapped wrongly");

  a_map_buffer: assert property ( // see [R15]
    wr_go && win_hit && aw_addr_q == 12'h2DC |=> fab_reg_number == 16'h1C20)
    else $error("buffer window word mapped wrongly");

  a_loader_copy: assert property ( // see [R6]
    ldr_take |=> station_addr == $past(ldr_bytes)
      && {host_station_addr_high, host_station_addr_low} == $past(ldr_bytes))
    else $error("loader bytes not placed in both copies");

  a_host_low_keep: assert property ( // see [R7]
    wr_go && init_done_q && !ldr_take && aw_addr_q == OFF_STATION_LOW
      && w_strb_q == 4'hF |=> (station_addr[31:0] == $past(w_data_q)) [*2])
    else $error("host low write not kept");

  a_high_rsvd: assert property ( // see [R1]
    rd_take && araddr == OFF_STATION_HIGH |=> rdata[31:16] == 16'h0000
      && rdata[15:0] == $past(station_addr[47:32]))
    else $error("high register readback wrong");

  c_window_write: cover property (wr_go && win_hit ##[1:20] fab_done);
  c_loader_run: cover property (ldr_take ##[1:50] ldr_done);
  c_host_mac_write: cover property (wr_go && init_done_q
                                    && aw_addr_q == OFF_STATION_HIGH);

endmodule

//--- verification/swcsr_fabric_model.sv
/*
 swcsr_fabric_model: stand-in for the fabric register set behind the
 direct-write window; takes one command, answers after a set delay.
 assumes: fab_req stays high until the edge after fab_done.
*/
`timescale 1ns/1ps
module swcsr_fabric_model
  import swcsr_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        fab_req,
  input  wire logic [15:0] fab_reg_number,
  input  wire logic [3:0]  fab_byte_enables,
  input  wire logic [31:0] fab_wdata,
  input  wire logic [3:0]  delay,
  output logic             fab_done,
  output logic [15:0]      num_q,
  output logic [31:0]      data_q
);
  // ==========================================================
  // command acceptance and completion
  logic [3:0] cnt_q;   // cycles waited on this command
  logic       armed_q; // ready for a new command

  // one done pulse per command, after delay cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 4'h0;
      armed_q  <= 1'b1;
      fab_done <= 1'b0;
      num_q    <= 16'h0000;
      data_q   <= 32'h00000000;
    end else begin
      fab_done <= 1'b0;
      if (!fab_req) begin
        cnt_q   <= 4'h0;
        armed_q <= 1'b1;
      end else if (armed_q && cnt_q == delay) begin
        fab_done <= 1'b1;
        armed_q  <= 1'b0;
        num_q    <= fab_reg_number;
        for (int b = 0; b < 4; b++) begin
          // cleared enables leave the byte alone
          if (fab_byte_enables[b]) begin
            data_q[8*b+:8] <= fab_wdata[8*b+:8];
          end
        end
      end else if (armed_q) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

//--- verification/testbench.sv
/*
 testbench: drives the station-address and direct-write block over
 AXI4-Lite, plays the loader, and checks the fabric commands.
 assumes: swcsr_fabric_model answers the fabric side.
*/
`timescale 1ns/1ps
module testbench
  import swcsr_pkg::*;
;
  // ==========================================================
  // signals
  logic        aclk, aresetn;             // clock, reset
  logic        awvalid, wvalid, bready;   // write channels
  logic        arvalid, rready;           // read channels
  logic        awready, wready, bvalid;   // write answers
  logic        arready, rvalid;           // read answers
  logic [11:0] awaddr, araddr;            // addresses
  logic [31:0] wdata, rdata;              // data
  logic [3:0]  wstrb, fab_be, delay;      // strobes, enables, delay
  logic [1:0]  bresp, rresp;              // responses
  logic        ldr_valid, ldr_prog;       // loader strobe, programmed
  logic        ldr_done;                  // init complete
  logic [47:0] ldr_bytes, station_addr;   // loader bytes, station
  logic [15:0] hs_high, fab_num, mdl_num; // copies, numbers
  logic [31:0] hs_low, fab_wdata, mdl_data;
  logic        fab_req, fab_rnw, busy, fab_done;
  int          errors, n_tests;           // counters

  // window addresses and their fabric numbers
  localparam logic [11:0] WA [9] = '{12'h200, 12'h204, 12'h208, 12'h234, 12'h238,
                                     12'h284, 12'h294, 12'h298, 12'h2DC};
  localparam logic [15:0] WN [9] = '{16'h0001, 16'h0004, 16'h0401, 16'h0C80, 16'h1800,
                                     16'h184D, 16'h1880, 16'h1C00, 16'h1C20};

  swcsr_top i_swcsr_top (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .ldr_valid(ldr_valid),
    .ldr_programmed(ldr_prog), .ldr_bytes(ldr_bytes), .ldr_done(ldr_done),
    .station_addr(station_addr), .host_station_addr_high(hs_high),
    .host_station_addr_low(hs_low), .fab_req(fab_req),
    .fab_reg_number(fab_num), .fab_byte_enables(fab_be),
    .fab_read_not_write(fab_rnw), .fab_wdata(fab_wdata),
    .fab_done(fab_done), .fabric_op_busy(busy));

  swcsr_fabric_model i_swcsr_fabric_model (.aclk(aclk), .aresetn(aresetn),
    .fab_req(fab_req), .fab_reg_number(fab_num), .fab_byte_enables(fab_be),
    .fab_wdata(fab_wdata), .delay(delay), .fab_done(fab_done),
    .num_q(mdl_num), .data_q(mdl_data));

  // ==========================================================
  // clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ==========================================================
  // reporting
  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("errors %0d, comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // bounded wait ran out
  task automatic hang(input string what);
    errors++;
    $display("wrong value at %0t ns: %s timed out", $time, what);
    give_verdict();
  endtask

  // ==========================================================
  // bus cycles
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    int n;
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 200) hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 200) hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // read a register and compare data and response
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(d, e, "read data");
    check(r, er, "read response");
  endtask

  task automatic wait_idle;
    int n;
    for (n = 0; n < 100 && busy !== 1'b0; n++) @(posedge aclk);
    if (busy !== 1'b0) hang("busy");
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_chk(OFF_STATION_HIGH, 32'h0000FFFF, AXI_OKAY);
    rd_chk(OFF_STATION_LOW, 32'hFF0F8000, AXI_OKAY);
    check(station_addr, 48'hFFFFFF0F8000, "station");
    rd_chk(OFF_CMD_STATUS, 32'h00000000, AXI_OKAY);
  endtask

  task automatic t_loader;
    logic [1:0] r;
    axi_wr(OFF_STATION_LOW, 32'h12345678, 4'hF, r);
    rd_chk(OFF_STATION_LOW, 32'hFF0F8000, AXI_OKAY);
    // strobe without a programmed eeprom: no change
    ldr_bytes <= 48'hA6A5A4A3A2A1;
    ldr_valid <= 1'b1;
    @(posedge aclk);
    ldr_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    check(station_addr, 48'hFFFFFF0F8000, "unprogrammed");
    ldr_prog  <= 1'b1;
    ldr_valid <= 1'b1;
    @(posedge aclk);
    ldr_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    rd_chk(OFF_STATION_HIGH, 32'h0000A6A5, AXI_OKAY);
    rd_chk(OFF_STATION_LOW, 32'hA4A3A2A1, AXI_OKAY);
    check(hs_high, 16'hA6A5, "host high");
    check(hs_low, 32'hA4A3A2A1, "host low");
    ldr_done <= 1'b1;
    @(posedge aclk);
    ldr_done <= 1'b0;
  endtask

  task automatic t_host;
    logic [1:0] r;
    axi_wr(OFF_STATION_HIGH, 32'hDEADBEEF, 4'hF, r);
    check(r, AXI_OKAY, "high response");
    rd_chk(OFF_STATION_HIGH, 32'h0000BEEF, AXI_OKAY);
    // only the two low bytes are strobed
    axi_wr(OFF_STATION_LOW, 32'h11223344, 4'h3, r);
    rd_chk(OFF_STATION_LOW, 32'hA4A33344, AXI_OKAY);
    check(station_addr, 48'hBEEFA4A33344, "station");
    // full word write after init is kept whole
    axi_wr(OFF_STATION_LOW, 32'h55667788, 4'hF, r);
    rd_chk(OFF_STATION_LOW, 32'h55667788, AXI_OKAY);
    check(station_addr, 48'hBEEF55667788, "station full");
  endtask

  task automatic t_window;
    logic [1:0]  r;
    logic [31:0] d;
    for (int i = 0; i < 9; i++) begin
      delay <= i[0] ? 4'h9 : 4'h0; // prompt and slow fabric
      d = {16'hC0DE, 4'h0, WA[i]};
      axi_wr(WA[i], d, 4'hF, r);
      check(r, AXI_OKAY, "window response");
      check({busy, fab_req, fab_rnw}, 3'b110, "busy write");
      check(fab_num, WN[i], "fabric number");
      check(fab_be, FAB_BE_ALL, "enables");
      check(fab_wdata, d, "fabric data");
      if (i[0]) begin
        rd_chk(OFF_CMD_STATUS, {2'b10, 10'h000, FAB_BE_ALL, WN[i]}, AXI_OKAY);
      end
      wait_idle();
      check(fab_req, 1'b0, "request released");
      check({mdl_num, mdl_data}, {WN[i], d}, "delivered");
    end
  endtask

  task automatic t_errors;
    logic [1:0] r;
    rd_chk(WIN_BASE, 32'h00000000, AXI_OKAY);
    axi_wr(12'h2E0, 32'h0000FFFF, 4'hF, r);
    check(r, AXI_SLVERR, "unmapped write");
    check(busy, 1'b0, "no command");
    rd_chk(12'h2E0, 32'h00000000, AXI_SLVERR);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    errors    = 0;
    n_tests   = 0;
    aresetn   = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 60'h0;
    {ldr_valid, ldr_prog, ldr_done} = 3'h0;
    ldr_bytes = 48'h0;
    delay     = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_loader();
    t_host();
    t_window();
    t_errors();
    give_verdict();
  end
endmodule
